// [lsf_top.sv]
// Operation
// - Line status shows oldest word flags
// - Status read leaves word flags set
// - Bit 7 follows live clear-to-send level
// - Clear-to-send bit taken from input after reset
// - Noise tags word, bit 5
// - Long low line pushes zero break word
// - Bad stop bit tags framing error, bit 3
// - Parity mismatch tags parity error, bit 2
// - Multidrop stores ninth bit as parity
// - Full fifo drops word, sets overrun
// - Overrun clears on status read or room
// - Stale flag after timeout period expires
// - Read or write restarts timeout, clears flag
// - Zero period disables stale detection
// - Line flags gated by per-bit enables
// - Special enables route event bits
// - Event register clears on read
// - Multidrop address word sets event 5
// - Line break sets event 4
// - Flow characters set events 0 to 3
// - Unused status, event, enable and top irq bits read as zero
// - Line error summary, clears on top read
// - Special summary, clears on top read
`include "lsf_cfg.svh"
`timescale 1ns/10ps
`default_nettype none
module lsf_top
  import lsf_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr,
  input  wire logic       rd,
  output logic      [7:0] rdata,
  // Receiver word events
  input  wire logic       rx_valid,
  input  wire logic [7:0] rx_data,
  input  wire logic       rx_noise,
  input  wire logic       rx_frame_err,
  input  wire logic       rx_parity_err,
  input  wire logic       rx_ninth,
  input  wire logic       rx_break,
  // Flow character matches
  input  wire logic       rx_resume1,
  input  wire logic       rx_resume2,
  input  wire logic       rx_stop1,
  input  wire logic       rx_stop2,
  // Timeout tick and pin
  input  wire logic       char_tick,
  input  wire logic       cts_pin,
  // Receive holding read out
  input  wire logic       hold_rd,
  output logic      [7:0] hold_data,
  output logic            rx_empty,
  // Summary bits
  output logic            line_error_summary,
  output logic            special_event_summary
);
  ////////////////////////////////////////////////////////////////////////
  // Registers and wires
  logic [7:0]  ls_irq_en_ff;
  logic [7:0]  special_char_irq_enable_ff;
  logic [7:0]  special_char_events_ff;
  logic [7:0]  mode_control_two_ff;
  logic [7:0]  receive_timeout_period_ff;
  logic [7:0]  stale_cnt_ff;
  logic        overrun_flag_ff;
  logic        stale_data_flag_ff;
  logic        line_err_ff;
  logic        special_ff;
  logic [7:0]  rdata_ff;
  logic        clear_to_send_level;
  lsf_word_t   head;
  lsf_word_t   wr_word;
  logic        fifo_full;
  logic        fifo_empty;

  // Address decode helper
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ref_a);
    hit = (a == ref_a);
  endfunction

  wire rd_ls    = rd && hit(addr, `LSF_ADDR_LINE_STATUS);
  wire rd_evt   = rd && hit(addr, `LSF_ADDR_SPECIAL_EVT);
  wire rd_top   = rd && hit(addr, `LSF_ADDR_TOP_IRQ);
  wire wr_spen  = wr && hit(addr, `LSF_ADDR_SPECIAL_EN);
  wire wr_lsen  = wr && hit(addr, `LSF_ADDR_LS_IRQ_EN);
  wire wr_mode  = wr && hit(addr, `LSF_ADDR_MODE_TWO);
  wire wr_tmo   = wr && hit(addr, `LSF_ADDR_RX_TIMEOUT);
  wire multidrop = mode_control_two_ff[`LSF_MODE_MULTIDROP];
  wire spec_on   = mode_control_two_ff[`LSF_MODE_SPECIAL];

  ////////////////////////////////////////////////////////////////////////
  // Clear-to-send synchroniser, live level
  lsf_sync u_cts (
    .clk (clk),
    .rst (rst),
    .d   (cts_pin),
    .q   (clear_to_send_level)
  );

  ////////////////////////////////////////////////////////////////////////
  // Word push: break forces zero data, multidrop keeps ninth bit
  wire push = rx_valid || rx_break;
  assign wr_word.data  = rx_break ? `LSF_ZERO_DATA : rx_data;
  assign wr_word.brk   = rx_break;
  assign wr_word.noise = rx_noise && !rx_break;
  assign wr_word.frame = rx_frame_err && !rx_break;
  assign wr_word.par   = rx_break ? 1'b0 :
                         multidrop ? rx_ninth : rx_parity_err;
  wire pop = hold_rd && !fifo_empty;

  // Flags travel inside the fifo entry
  lsf_fifo #(
    .DEPTH (DEPTH),
    .AW    (AW)
  ) u_fifo (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (push),
    .wr_word (wr_word),
    .rd_en   (hold_rd),
    .head    (head),
    .empty   (fifo_empty),
    .full    (fifo_full)
  );

  assign hold_data = fifo_empty ? `LSF_ZERO_DATA : head.data;
  assign rx_empty  = fifo_empty;

  ////////////////////////////////////////////////////////////////////////
  // Line status byte
  wire [5:0] word_flags = fifo_empty ? 6'h00 :
    {head.noise, head.brk, head.frame, head.par, 2'b00};
  wire [7:0] line_status = {clear_to_send_level, 1'b0,
    word_flags[5:2], overrun_flag_ff, stale_data_flag_ff};
  wire [5:0] ls_masked = line_status[5:0] & ls_irq_en_ff[5:0];

  // Special character events
  wire md_addr = rx_valid && multidrop && rx_ninth;
  wire [5:0] evt_set = {md_addr, rx_break,
    spec_on & rx_stop2, spec_on & rx_stop1,
    spec_on & rx_resume2, spec_on & rx_resume1};
  wire [5:0] evt_routed = special_char_events_ff[5:0] &
                          special_char_irq_enable_ff[5:0];

  ////////////////////////////////////////////////////////////////////////
  // Overrun flag: set wins over clear
  // A full fifo refuses the word even when a pop shares the edge
  wire ovr_set = push && fifo_full;
  wire ovr_clr = rd_ls || !fifo_full;
  wire nxt_overrun = ovr_set || (overrun_flag_ff && !ovr_clr);

  // Stale timer
  wire tmo_restart = push || pop;
  wire tmo_off = (receive_timeout_period_ff == `LSF_RST_BYTE);
  wire tmo_hit = char_tick && !fifo_empty && !tmo_off &&
                 (stale_cnt_ff >= receive_timeout_period_ff);

  ////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ls_irq_en_ff               <= `LSF_RST_BYTE;
      special_char_irq_enable_ff <= `LSF_RST_BYTE;
      mode_control_two_ff        <= `LSF_RST_BYTE;
      receive_timeout_period_ff  <= `LSF_RST_BYTE;
    end else begin
      if (wr_lsen) ls_irq_en_ff <= wdata & `LSF_EVT_MASK;
      if (wr_spen) special_char_irq_enable_ff <= wdata & `LSF_EVT_MASK;
      if (wr_mode) mode_control_two_ff <= wdata;
      if (wr_tmo) receive_timeout_period_ff <= wdata;
    end
  end

  // Event bits, set wins over read clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      special_char_events_ff <= `LSF_RST_BYTE;
    end else begin
      special_char_events_ff <= {2'b00, evt_set |
        (rd_evt ? 6'h00 : special_char_events_ff[5:0])};
    end
  end

  // Overrun and stale flags
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      overrun_flag_ff    <= 1'b0;
      stale_data_flag_ff <= 1'b0;
      stale_cnt_ff       <= `LSF_RST_BYTE;
    end else begin
      overrun_flag_ff <= nxt_overrun;
      if (tmo_restart) begin
        stale_cnt_ff       <= `LSF_RST_BYTE;
        stale_data_flag_ff <= 1'b0;
      end else begin
        if (char_tick && !tmo_hit && !fifo_empty) begin
          stale_cnt_ff <= stale_cnt_ff + 8'h01;
        end
        if (tmo_hit) stale_data_flag_ff <= 1'b1;
        if (tmo_off) stale_data_flag_ff <= 1'b0;
      end
    end
  end

  // Summary bits, set wins over top read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      line_err_ff <= 1'b0;
      special_ff  <= 1'b0;
    end else begin
      line_err_ff <= (|ls_masked) || (line_err_ff && !rd_top);
      special_ff  <= (|evt_routed) || (special_ff && !rd_top);
    end
  end

  assign line_error_summary    = line_err_ff;
  assign special_event_summary = special_ff;

  ////////////////////////////////////////////////////////////////////////
  // Read data mux
  wire [7:0] top_irq = {6'h00, special_ff, line_err_ff};
  wire [7:0] rd_mux =
    hit(addr, `LSF_ADDR_LINE_STATUS) ? line_status :
    hit(addr, `LSF_ADDR_SPECIAL_EN)  ? special_char_irq_enable_ff :
    hit(addr, `LSF_ADDR_SPECIAL_EVT) ? special_char_events_ff :
    hit(addr, `LSF_ADDR_LS_IRQ_EN)   ? ls_irq_en_ff :
    hit(addr, `LSF_ADDR_MODE_TWO)    ? mode_control_two_ff :
    hit(addr, `LSF_ADDR_RX_TIMEOUT)  ? receive_timeout_period_ff :
    hit(addr, `LSF_ADDR_TOP_IRQ)     ? top_irq : `LSF_RST_BYTE;

  // Registered read data
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_ff <= `LSF_RST_BYTE;
    end else begin
      rdata_ff <= rd ? rd_mux : `LSF_RST_BYTE;
    end
  end

  assign rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  cts_follow_a: assert property (@(posedge clk) disable iff (rst)
    rd_ls |=> rdata[`LSF_BIT_CTS] == $past(clear_to_send_level))
    else $error("cts bit wrong");
  empty_zero_a: assert property (@(posedge clk) disable iff (rst)
    fifo_empty |-> line_status[5:2] == 4'h0)
    else $error("flags shown while empty");
  ovr_set_a: assert property (@(posedge clk) disable iff (rst)
    (push && fifo_full) |=> overrun_flag_ff)
    else $error("overrun not set");
  ovr_clear_a: assert property (@(posedge clk) disable iff (rst)
    (overrun_flag_ff && rd_ls && !push) |=> !overrun_flag_ff)
    else $error("overrun not cleared");
  stale_clr_a: assert property (@(posedge clk) disable iff (rst)
    tmo_restart |=> !stale_data_flag_ff && stale_cnt_ff == 8'h00)
    else $error("stale not restarted");
  stale_off_a: assert property (@(posedge clk) disable iff (rst)
    tmo_off |=> !stale_data_flag_ff)
    else $error("stale while disabled");
  evt_clear_a: assert property (@(posedge clk) disable iff (rst)
    (rd_evt && evt_set == 6'h00) |=> special_char_events_ff == 8'h00)
    else $error("events not cleared");
  brk_evt_a: assert property (@(posedge clk) disable iff (rst)
    rx_break |=> special_char_events_ff[4])
    else $error("break event missing");
  line_sum_a: assert property (@(posedge clk) disable iff (rst)
    (|ls_masked) |=> line_error_summary)
    else $error("line summary missing");
  spec_sum_a: assert property (@(posedge clk) disable iff (rst)
    (|evt_routed) |=> special_event_summary)
    else $error("special summary missing");

  // Word flag checks, a word into an empty fifo is the head at once
  wire first_word = rx_valid && fifo_empty;
  wire first_brk  = rx_break && fifo_empty;
  noise_tag_a: assert property (@(posedge clk) disable iff (rst)
    first_word |=> line_status[`LSF_BIT_NOISE] == $past(rx_noise))
    else $error("noise flag wrong");
  frame_tag_a: assert property (@(posedge clk) disable iff (rst)
    first_word |=> line_status[`LSF_BIT_FRAME] == $past(rx_frame_err))
    else $error("framing flag wrong");
  par_tag_a: assert property (@(posedge clk) disable iff (rst)
    (first_word && !multidrop) |=>
      line_status[`LSF_BIT_PARITY] == $past(rx_parity_err))
    else $error("parity flag wrong");
  ninth_tag_a: assert property (@(posedge clk) disable iff (rst)
    (first_word && multidrop) |=>
      line_status[`LSF_BIT_PARITY] == $past(rx_ninth))
    else $error("ninth bit wrong");
  brk_word_a: assert property (@(posedge clk) disable iff (rst)
    first_brk |=> line_status[`LSF_BIT_BREAK] && hold_data == `LSF_ZERO_DATA)
    else $error("break word wrong");
  flags_hold_a: assert property (@(posedge clk) disable iff (rst)
    (!fifo_empty && !pop) |=> $stable(line_status[5:2]))
    else $error("word flags moved");
  head_kept_a: assert property (@(posedge clk) disable iff (rst)
    (!fifo_empty && !pop) |=> $stable(hold_data))
    else $error("head word moved");
  unused_zero_a: assert property (@(posedge clk) disable iff (rst)
    !line_status[6] && special_char_events_ff[7:6] == 2'b00 &&
    special_char_irq_enable_ff[7:6] == 2'b00)
    else $error("unused bits set");

  // Overrun and stale checks
  keep_full_a: assert property (@(posedge clk) disable iff (rst)
    (push && fifo_full && !pop) |=> fifo_full && $stable(hold_data))
    else $error("full fifo changed");
  room_clear_a: assert property (@(posedge clk) disable iff (rst)
    (overrun_flag_ff && !fifo_full) |=> !overrun_flag_ff)
    else $error("overrun kept with room");
  stale_set_a: assert property (@(posedge clk) disable iff (rst)
    (tmo_hit && !tmo_restart) |=> stale_data_flag_ff)
    else $error("stale not set");
  stale_need_a: assert property (@(posedge clk) disable iff (rst)
    fifo_empty |-> !stale_data_flag_ff)
    else $error("stale while empty");

  // Event and summary checks
  wire [3:0] flow_hit = {rx_stop2, rx_stop1, rx_resume2, rx_resume1};
  addr_evt_a: assert property (@(posedge clk) disable iff (rst)
    (rx_valid && multidrop && rx_ninth) |=> special_char_events_ff[5])
    else $error("address event missing");
  flow_evt_a: assert property (@(posedge clk) disable iff (rst)
    spec_on |=> (special_char_events_ff[3:0] & $past(flow_hit)) ==
      $past(flow_hit))
    else $error("flow event missing");
  flow_off_a: assert property (@(posedge clk) disable iff (rst)
    (!spec_on && !rd_evt && special_char_events_ff[3:0] == 4'h0) |=>
      special_char_events_ff[3:0] == 4'h0)
    else $error("flow event while off");
  line_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!line_err_ff && ls_masked == 6'h00) |=> !line_error_summary)
    else $error("line summary unmasked");
  spec_quiet_a: assert property (@(posedge clk) disable iff (rst)
    (!special_ff && evt_routed == 6'h00) |=> !special_event_summary)
    else $error("special summary unmasked");
endmodule // lsf_top
`default_nettype wire

// [lsf_cfg.svh]
`ifndef LSF_CFG_SVH
`define LSF_CFG_SVH

// Register offsets
`define LSF_ADDR_LINE_STATUS   8'h04
`define LSF_ADDR_SPECIAL_EN    8'h05
`define LSF_ADDR_SPECIAL_EVT   8'h06
`define LSF_ADDR_LS_IRQ_EN     8'h03
`define LSF_ADDR_MODE_TWO      8'h0a
`define LSF_ADDR_RX_TIMEOUT    8'h0b
`define LSF_ADDR_TOP_IRQ       8'h02

// Line status bit positions
`define LSF_BIT_CTS            7
`define LSF_BIT_NOISE          5
`define LSF_BIT_BREAK          4
`define LSF_BIT_FRAME          3
`define LSF_BIT_PARITY         2
`define LSF_BIT_OVERRUN        1
`define LSF_BIT_STALE          0

// Mode two bit positions
`define LSF_MODE_MULTIDROP     6
`define LSF_MODE_SPECIAL       4

// Top irq status bit positions
`define LSF_TOP_LINE_ERR       0
`define LSF_TOP_SPECIAL        1

// Reset values and field masks
`define LSF_RST_BYTE           8'h00
`define LSF_EVT_MASK           8'h3f
`define LSF_ZERO_DATA          8'h00

`endif

// [lsf_pkg.sv]
package lsf_pkg;
  // Fields stored beside each received word
  typedef struct packed {
    logic noise;
    logic brk;
    logic frame;
    logic par;
    logic [7:0] data;
  } lsf_word_t;

  // Receive event kinds
  typedef enum logic [1:0] {
    LSF_EV_DATA,
    LSF_EV_BREAK
  } lsf_kind_t;
endpackage

// [lsf_sync.sv]
`timescale 1ns/10ps
`default_nettype none
module lsf_sync (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // Level in and out
  input  wire logic d,
  output logic      q
);
  logic s1_ff;
  logic s2_ff;

  // Two-stage synchroniser
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
    end else begin
      s1_ff <= d;
      s2_ff <= s1_ff;
    end
  end

  assign q = s2_ff;
endmodule // lsf_sync
`default_nettype wire

// [lsf_fifo.sv]
`timescale 1ns/10ps
`default_nettype none
module lsf_fifo
  import lsf_pkg::*;
#(
  parameter int DEPTH = 128,
  parameter int AW    = 7
) (
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst,
  // Write side
  input  wire logic      wr_en,
  input  wire lsf_word_t wr_word,
  // Read side
  input  wire logic      rd_en,
  output lsf_word_t      head,
  output logic           empty,
  output logic           full
);
  lsf_word_t      mem_ff [DEPTH];
  logic [AW-1:0]  wp_ff;
  logic [AW-1:0]  rp_ff;
  logic [AW:0]    cnt_ff;
  wire            do_wr = wr_en && !full;
  wire            do_rd = rd_en && !empty;

  assign empty = (cnt_ff == '0);
  assign full  = (cnt_ff == (AW+1)'(DEPTH));
  assign head  = mem_ff[rp_ff];

  // Storage, words with their flags
  always_ff @(posedge clk) begin
    if (do_wr) begin
      mem_ff[wp_ff] <= wr_word;
    end
  end

  // Pointers and fill level
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wp_ff  <= '0;
      rp_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      if (do_wr) begin
        wp_ff <= (wp_ff == AW'(DEPTH-1)) ? '0 : wp_ff + 1'b1;
      end
      if (do_rd) begin
        rp_ff <= (rp_ff == AW'(DEPTH-1)) ? '0 : rp_ff + 1'b1;
      end
      cnt_ff <= cnt_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
    end
  end
endmodule // lsf_fifo
`default_nettype wire

// [lsf_rx_model.sv]
`timescale 1ns/10ps
`default_nettype none
module lsf_rx_model (
  // Clock
  input  wire logic       clk,
  // Word toward the block, tags {noise, frame, parity, ninth}
  output logic            rx_valid,
  output logic      [7:0] rx_data,
  output logic      [3:0] rx_tags,
  // Break and flow matches {stop2, stop1, resume2, resume1}
  output logic            rx_break,
  output logic      [3:0] rx_flow
);
  // Idle lines at time zero
  initial begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    rx_tags  = 4'h0;
    rx_break = 1'b0;
    rx_flow  = 4'h0;
  end

  // One word, tags valid only beside the strobe
  task automatic word(input logic [7:0] d, input logic [3:0] t);
    @(posedge clk);
    rx_valid <= 1'b1;
    rx_data  <= d;
    rx_tags  <= t;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~d; // Released lines do not keep the value
    rx_tags  <= ~t;
  endtask

  // Break or flow pulse, never beside a word
  task automatic pulse(input logic b, input logic [3:0] f);
    @(posedge clk);
    rx_break <= b;
    rx_flow  <= f;
    @(posedge clk);
    rx_break <= 1'b0;
    rx_flow  <= 4'h0;
  endtask
endmodule // lsf_rx_model
`default_nettype wire

// [lsf_top_tb.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
  miscompares++; $display("Error %s exp %h got %h", nm, e, g); end end
module lsf_top_tb;
  import lsf_pkg::*;
  logic       clk, rst, wr, rd, hold_rd, char_tick, cts_pin, c;
  logic [7:0] addr, wdata, rdata, hold_data, d;
  logic       rx_valid, rx_break, rx_empty, les, ses;
  logic [3:0] t, tags, flow;
  logic [7:0] rx_data;
  int         miscompares, checks_done, i;

  // Far side transmitter
  lsf_rx_model i_lsf_rx_model (.clk(clk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_tags(tags), .rx_break(rx_break),
    .rx_flow(flow));

  // Block under test, small fifo
  lsf_top #(.DEPTH(4), .AW(2)) i_lsf_top (.clk(clk), .rst(rst),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_noise(tags[3]),
    .rx_frame_err(tags[2]), .rx_parity_err(tags[1]),
    .rx_ninth(tags[0]), .rx_break(rx_break), .rx_resume1(flow[0]),
    .rx_resume2(flow[1]), .rx_stop1(flow[2]), .rx_stop2(flow[3]),
    .char_tick(char_tick), .cts_pin(cts_pin), .hold_rd(hold_rd),
    .hold_data(hold_data), .rx_empty(rx_empty),
    .line_error_summary(les), .special_event_summary(ses));

  ////////////////////////////////////////////////////////////////////////
  // Expected line status for one head word
  function automatic logic [7:0] lsr_exp(logic cts, logic [3:0] w,
                                         logic md);
    return {cts, 1'b0, w[3], 1'b0, w[2], md ? w[0] : w[1], 2'b00};
  endfunction

  // Register write
  task automatic wr_reg(input logic [7:0] a, v);
    @(posedge clk);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= v;
    @(posedge clk);
    wr    <= 1'b0;
  endtask

  // Register read and compare in the answer cycle
  task automatic rd_chk(input string nm, input logic [7:0] a, e);
    @(posedge clk);
    rd   <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask

  // Pop one word from the holding register
  task automatic pop();
    @(posedge clk);
    hold_rd <= 1'b1;
    @(posedge clk);
    hold_rd <= 1'b0;
    #1;
  endtask

  // Timeout unit pulses
  task automatic tick(input int n);
    repeat (n) begin
      @(posedge clk);
      char_tick <= 1'b1;
      @(posedge clk);
      char_tick <= 1'b0;
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Watchdog
  initial begin
    #100000;
    miscompares++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    {rst, wr, rd, hold_rd, char_tick, cts_pin} = 6'b100001;
    addr  = 8'h00;
    wdata = 8'h00;
    void'($urandom(96));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    rd_chk("lsr reset", 8'h04, 8'h80);
    rd_chk("spec en reset", 8'h05, 8'h00);
    rd_chk("unmapped", 8'h3f, 8'h00);
    wr_reg(8'h05, 8'hff);
    rd_chk("spec en bits", 8'h05, 8'h3f);
    wr_reg(8'h05, 8'h00);
    // Random words, flags follow the head word
    for (i = 0; i < 8; i++) begin
      d = 8'($urandom);
      t = 4'($urandom);
      c = 1'($urandom);
      cts_pin <= c;
      i_lsf_rx_model.word(d, t);
      repeat (3) @(posedge clk);
      rd_chk("lsr", 8'h04, lsr_exp(c, t, 1'b0));
      rd_chk("lsr kept", 8'h04, lsr_exp(c, t, 1'b0));
      `CHK("head data", d, hold_data)
      `CHK("gated sum", 1'b0, les)
      pop();
      `CHK("empty", 1'b1, rx_empty)
    end
    cts_pin <= 1'b1;
    // Break word and its event
    wr_reg(8'h05, 8'h10);
    i_lsf_rx_model.pulse(1'b1, 4'h0);
    repeat (3) @(posedge clk);
    rd_chk("break lsr", 8'h04, 8'h90);
    `CHK("break data", 8'h00, hold_data)
    `CHK("spec sum", 1'b1, ses)
    rd_chk("break evt", 8'h06, 8'h10);
    rd_chk("evt clear", 8'h06, 8'h00);
    rd_chk("top", 8'h02, 8'h02);
    @(posedge clk);
    #1;
    `CHK("spec sum clr", 1'b0, ses)
    pop();
    // Flow characters with detection off, then on
    wr_reg(8'h0a, 8'h40);
    i_lsf_rx_model.pulse(1'b0, 4'hf);
    rd_chk("flow off", 8'h06, 8'h00);
    wr_reg(8'h0a, 8'h50);
    for (i = 0; i < 4; i++) begin
      i_lsf_rx_model.pulse(1'b0, 4'(1 << i));
      rd_chk("flow evt", 8'h06, 8'(1 << i));
    end
    // Multidrop ninth bit in parity place
    i_lsf_rx_model.word(8'h5a, 4'h1);
    rd_chk("addr lsr", 8'h04, 8'h84);
    rd_chk("addr evt", 8'h06, 8'h20);
    pop();
    i_lsf_rx_model.word(8'h5b, 4'h2);
    rd_chk("no parity", 8'h04, 8'h80);
    pop();
    wr_reg(8'h0a, 8'h00);
    // Overrun on a full fifo
    for (i = 0; i < 5; i++) begin
      i_lsf_rx_model.word(8'(i + 1), 4'h0);
    end
    rd_chk("overrun", 8'h04, 8'h82);
    rd_chk("overrun read", 8'h04, 8'h80);
    i_lsf_rx_model.word(8'h09, 4'h0);
    pop();
    rd_chk("overrun room", 8'h04, 8'h80);
    for (i = 2; i < 5; i++) begin
      `CHK("kept data", 8'(i), hold_data)
      pop();
    end
    // Stale data timeout and line error summary
    wr_reg(8'h0b, 8'h02);
    wr_reg(8'h03, 8'h01);
    i_lsf_rx_model.word(8'h33, 4'h0);
    tick(1);
    rd_chk("not stale", 8'h04, 8'h80);
    tick(3);
    rd_chk("stale", 8'h04, 8'h81);
    `CHK("line sum", 1'b1, les)
    rd_chk("top line", 8'h02, 8'h01);
    i_lsf_rx_model.word(8'h44, 4'h0);
    rd_chk("stale new", 8'h04, 8'h80);
    tick(4);
    pop();
    rd_chk("stale pop", 8'h04, 8'h80);
    pop();
    wr_reg(8'h0b, 8'h00);
    i_lsf_rx_model.word(8'h55, 4'h0);
    tick(6);
    rd_chk("stale off", 8'h04, 8'h80);
    report_and_stop();
  end
endmodule // lsf_top_tb
`default_nettype wire
